// >>> rtl/pcm_channel.sv
// Purpose: Combinational mode decode for one tester pin channel
// Assumes: Control inputs already sampled and resolved to single-ended bits
// Notes: No state; the top owns mode bits and comparator sampling
`timescale 1ns/1ps
module pcm_channel
	import pcm_pkg::*;
(
	input wire logic drive_level,
	input wire logic receive_select,
	input wire logic load_on_input,
	input wire logic [4:0] mode,
	output pcm_drv_e drv_state,
	output logic [1:0] level_sel,
	output logic drive_en,
	output logic [6:0] slew_pct,
	output logic clamp_en,
	output logic load_en,
	output logic leak_mode
);
	logic low_leak_select;
	logic term_select;
	logic load_diag_force;
	logic [1:0] slew_code;
	assign low_leak_select = mode[PCM_F_LEAK];
	assign term_select = mode[PCM_F_TERM];
	assign load_diag_force = mode[PCM_F_DIAG];
	assign slew_code = {mode[PCM_F_SC_HI], mode[PCM_F_SC_LO]};

	// ----------------------------------------
	// Driver decode
	// ----------------------------------------
	always_comb begin
		if (low_leak_select) begin
			drv_state = PCM_DRV_LEAK;
		end else if (!receive_select) begin
			drv_state = drive_level ? PCM_DRV_HIGH : PCM_DRV_LOW;
		end else begin
			drv_state = term_select ? PCM_DRV_TERM : PCM_DRV_HIZ;
		end
	end

	always_comb begin
		case (drv_state)
			PCM_DRV_HIGH: level_sel = PCM_LVL_HIGH;
			PCM_DRV_LOW: level_sel = PCM_LVL_LOW;
			PCM_DRV_TERM: level_sel = PCM_LVL_TERM;
			default: level_sel = PCM_LVL_NONE;
		endcase
	end

	always_comb begin
		case (slew_code)
			PCM_SC_100: slew_pct = PCM_RATE_100;
			PCM_SC_75: slew_pct = PCM_RATE_75;
			PCM_SC_50: slew_pct = PCM_RATE_50;
			PCM_SC_25: slew_pct = PCM_RATE_25;
			default: slew_pct = PCM_RATE_100;
		endcase
	end

	// ----------------------------------------
	// Enables; leakage drops all three together
	// ----------------------------------------
	assign drive_en = (level_sel != PCM_LVL_NONE);
	assign clamp_en = (drv_state == PCM_DRV_HIZ);
	// Load follows its input unless forced for diagnostics or dropped in leakage
	assign load_en = !low_leak_select && (load_diag_force || load_on_input);
	assign leak_mode = low_leak_select;
endmodule

// >>> rtl/pcm_pkg.sv
// Purpose: Shared constants and types for the pin channel mode decode
// Assumes: Two channels, five latched mode bits each
// Notes: Slew percentages kept as printed
package pcm_pkg;
	localparam int PCM_NUM_CH = 2;
	localparam int PCM_MODE_W = 5;
	// Mode word field positions
	localparam int PCM_F_LEAK = 4;
	localparam int PCM_F_TERM = 3;
	localparam int PCM_F_SC_HI = 2;
	localparam int PCM_F_SC_LO = 1;
	localparam int PCM_F_DIAG = 0;
	// Reset mode word: low-leakage set, everything else clear
	localparam logic [4:0] PCM_MODE_RST = 5'h10;
	// Slew codes and rates in percent of full rate
	localparam logic [1:0] PCM_SC_100 = 2'h0;
	localparam logic [1:0] PCM_SC_75 = 2'h1;
	localparam logic [1:0] PCM_SC_50 = 2'h2;
	localparam logic [1:0] PCM_SC_25 = 2'h3;
	localparam logic [6:0] PCM_RATE_100 = 7'h64;
	localparam logic [6:0] PCM_RATE_75 = 7'h4B;
	localparam logic [6:0] PCM_RATE_50 = 7'h32;
	localparam logic [6:0] PCM_RATE_25 = 7'h19;
	// Driver level select encoding
	localparam logic [1:0] PCM_LVL_HIGH = 2'h0;
	localparam logic [1:0] PCM_LVL_LOW = 2'h1;
	localparam logic [1:0] PCM_LVL_TERM = 2'h2;
	localparam logic [1:0] PCM_LVL_NONE = 2'h3;
	typedef enum logic [2:0] {
		PCM_DRV_HIGH,
		PCM_DRV_LOW,
		PCM_DRV_TERM,
		PCM_DRV_HIZ,
		PCM_DRV_LEAK
	} pcm_drv_e;
endpackage

// >>> rtl/pcm_top.sv
// Purpose: Two-channel pin mode decode with latched mode bits
// Assumes: Control and comparator inputs arrive from pins, async to ref_clk
// Notes: Decode is combinational on synchronised inputs
// How it works
// - Driver picks high, low or termination level
// - Drive mode: level input selects high/low
// - Receive mode: term bit selects term or hi-Z
// - Slew code maps to 100/75/50/25 percent
// - Clamps enabled only in high-impedance
// - Comparator out high when pin exceeds threshold
// - Two independent comparators per channel
// - Load follows load input in normal mode
// - Diagnostic force enables load regardless of load input, except in low-leakage
// - Low-leakage overrides all other settings except the slew code, which still sets slew_pct
// - Enabled load connects sources, else diverts
// - Two identical independent channels
// - Reset sets low-leakage on both channels
// - Comparators keep working in low-leakage
// - Five latched mode bits per channel
`timescale 1ns/1ps
module pcm_top
	import pcm_pkg::*;
#(
	parameter int NUM_CH = PCM_NUM_CH
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [NUM_CH-1:0] drive_level_select_true,
	input wire logic [NUM_CH-1:0] drive_level_select_comp,
	input wire logic [NUM_CH-1:0] receive_select_true,
	input wire logic [NUM_CH-1:0] receive_select_comp,
	input wire logic [NUM_CH-1:0] load_on_input_true,
	input wire logic [NUM_CH-1:0] load_on_input_comp,
	input wire logic [NUM_CH-1:0] mode_load,
	input wire logic [PCM_MODE_W-1:0] mode_word,
	input wire logic [NUM_CH-1:0] high_cmp_raw,
	input wire logic [NUM_CH-1:0] low_cmp_raw,
	output logic [NUM_CH-1:0] high_compare_out,
	output logic [NUM_CH-1:0] low_compare_out,
	output logic [2*NUM_CH-1:0] level_sel,
	output logic [NUM_CH-1:0] drive_en,
	output logic [7*NUM_CH-1:0] slew_pct,
	output logic [NUM_CH-1:0] clamp_en,
	output logic [NUM_CH-1:0] load_en,
	output logic [NUM_CH-1:0] load_to_bridge,
	output logic [NUM_CH-1:0] load_to_ground,
	output logic [NUM_CH-1:0] leak_mode
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0][PCM_MODE_W-1:0] mode;
		logic [NUM_CH-1:0][2:0] s_drv;
		logic [NUM_CH-1:0][2:0] s_rcv;
		logic [NUM_CH-1:0][2:0] s_ld;
		logic [NUM_CH-1:0][2:0] s_ch;
		logic [NUM_CH-1:0][2:0] s_cl;
		logic [NUM_CH-1:0] drv;
		logic [NUM_CH-1:0] rcv;
		logic [NUM_CH-1:0] ld;
		logic [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0] cl;
	} pcm_state_s;

	pcm_state_s st_r;
	pcm_state_s st_nxt;

	// Agreed value moves only when stages two and three match
	function automatic logic settle(input logic [2:0] s, input logic cur);
		settle = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < NUM_CH; i++) begin
			// Differential pair: true above complement reads as 1
			st_nxt.s_drv[i] = {st_r.s_drv[i][1:0],
				drive_level_select_true[i] & ~drive_level_select_comp[i]};
			st_nxt.s_rcv[i] = {st_r.s_rcv[i][1:0],
				receive_select_true[i] & ~receive_select_comp[i]};
			st_nxt.s_ld[i] = {st_r.s_ld[i][1:0],
				load_on_input_true[i] & ~load_on_input_comp[i]};
			// Comparators sampled regardless of leakage mode
			st_nxt.s_ch[i] = {st_r.s_ch[i][1:0], high_cmp_raw[i]};
			st_nxt.s_cl[i] = {st_r.s_cl[i][1:0], low_cmp_raw[i]};
			st_nxt.drv[i] = settle(st_r.s_drv[i], st_r.drv[i]);
			st_nxt.rcv[i] = settle(st_r.s_rcv[i], st_r.rcv[i]);
			st_nxt.ld[i] = settle(st_r.s_ld[i], st_r.ld[i]);
			st_nxt.ch[i] = settle(st_r.s_ch[i], st_r.ch[i]);
			st_nxt.cl[i] = settle(st_r.s_cl[i], st_r.cl[i]);
			if (mode_load[i]) begin
				st_nxt.mode[i] = mode_word;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_r <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				st_r.mode[i] <= PCM_MODE_RST;
			end
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Per-channel decode
	// ----------------------------------------
	// Trade-off: decode is combinational, so outputs glitch with inputs
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic [6:0] pct;
		logic [1:0] lvl;
		logic le;
		pcm_channel u_ch (
			.drive_level(st_r.drv[g]),
			.receive_select(st_r.rcv[g]),
			.load_on_input(st_r.ld[g]),
			.mode(st_r.mode[g]),
			.drv_state(),
			.level_sel(lvl),
			.drive_en(drive_en[g]),
			.slew_pct(pct),
			.clamp_en(clamp_en[g]),
			.load_en(le),
			.leak_mode(leak_mode[g])
		);
		assign level_sel[2*g +: 2] = lvl;
		assign slew_pct[7*g +: 7] = pct;
		assign load_en[g] = le;
		assign load_to_bridge[g] = le;
		assign load_to_ground[g] = ~le;
		assign high_compare_out[g] = st_r.ch[g];
		assign low_compare_out[g] = st_r.cl[g];
	end
endmodule

// >>> testbench/pcm_fmt_model.sv
// Purpose: Timing formatter model for the fast control pairs
// Assumes: Ideal swing, no skew between true and complement
// Notes: Complement is never left equal to true
`timescale 1ns/1ps
module pcm_fmt_model (
	input wire logic [5:0] bits,
	output logic [5:0] pos,
	output logic [5:0] neg
);
	assign pos = bits;
	assign neg = ~bits;
endmodule

// >>> testbench/pcm_props.sv
// Purpose: Port checks for pcm_top
// Assumes: Channel 0 stands for both in the decode checks; comparator, routing and reset checks cover both
// Notes: Bound from the bench
`timescale 1ns/1ps
module pcm_props
	import pcm_pkg::*;
#(parameter int NUM_CH = PCM_NUM_CH)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [NUM_CH-1:0] mode_load,
	input wire logic [PCM_MODE_W-1:0] mode_word,
	input wire logic [NUM_CH-1:0] high_cmp_raw,
	input wire logic [NUM_CH-1:0] low_cmp_raw,
	input wire logic [NUM_CH-1:0] high_compare_out,
	input wire logic [NUM_CH-1:0] low_compare_out,
	input wire logic [2*NUM_CH-1:0] level_sel,
	input wire logic [NUM_CH-1:0] drive_en,
	input wire logic [7*NUM_CH-1:0] slew_pct,
	input wire logic [NUM_CH-1:0] clamp_en,
	input wire logic [NUM_CH-1:0] load_en,
	input wire logic [NUM_CH-1:0] load_to_bridge,
	input wire logic [NUM_CH-1:0] load_to_ground,
	input wire logic [NUM_CH-1:0] leak_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Three sync stages, so four steady samples must settle the outputs
	sequence raw_steady_s; $stable({high_cmp_raw, low_cmp_raw}) [*4]; endsequence
	cmp_follow_a: assert property (raw_steady_s |->
		{high_compare_out, low_compare_out} == {high_cmp_raw, low_cmp_raw}) else $error("cmp lag");
	leak_load_a: assert property (mode_load[0] |=> leak_mode[0] == $past(mode_word[4]))
		else $error("leak bit");
	slew_code_a: assert property (mode_load[0] |=>
		slew_pct[6:0] == PCM_RATE_100 - PCM_RATE_25 * $past(mode_word[2:1])) else $error("slew");
	clamp_hiz_a: assert property (clamp_en[0] == (level_sel[1:0] == PCM_LVL_NONE && !leak_mode[0]))
		else $error("clamp");
	drive_level_a: assert property (drive_en[0] == (level_sel[1:0] != PCM_LVL_NONE)
		&& drive_en[0] == (!leak_mode[0] && !clamp_en[0])) else $error("drive");
	leak_off_a: assert property (leak_mode[0] |-> !drive_en[0] && !clamp_en[0] && !load_en[0])
		else $error("leak off");
	load_route_a: assert property (load_to_bridge == load_en && load_to_ground == ~load_en)
		else $error("route");
	reset_leak_a: assert property ($rose(rst_b) |-> &leak_mode) else $error("reset");
endmodule

// >>> testbench/pin_channel_mode_decode_bench.sv
// Purpose: Self-checking bench for pcm_top
// Assumes: Pins settle within four edges of a change
// Notes: Channel 1 stays in low leakage while channel 0 is swept
`timescale 1ns/1ps
module pin_channel_mode_decode_bench;
	import pcm_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] dl = 2'h0, rs = 2'h0, lo = 2'h0, ml = 2'h0, hr = 2'h0, lr = 2'h0;
	logic [4:0] mw = 5'h00;
	wire logic [5:0] pt, pc;
	logic [1:0] hco, lco, den, cen, len, lbr, lgd, lkm, elv;
	logic [3:0] lvs;
	logic [13:0] slw;
	logic [5:0] v;
	logic [6:0] es;
	logic ecl, eld;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	pcm_fmt_model fmt_u (.bits({lo, rs, dl}), .pos(pt), .neg(pc));
	pcm_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .drive_level_select_true(pt[1:0]),
		.drive_level_select_comp(pc[1:0]), .receive_select_true(pt[3:2]),
		.receive_select_comp(pc[3:2]), .load_on_input_true(pt[5:4]), .load_on_input_comp(pc[5:4]),
		.mode_load(ml), .mode_word(mw), .high_cmp_raw(hr), .low_cmp_raw(lr),
		.high_compare_out(hco), .low_compare_out(lco), .level_sel(lvs), .drive_en(den),
		.slew_pct(slw), .clamp_en(cen), .load_en(len), .load_to_bridge(lbr),
		.load_to_ground(lgd), .leak_mode(lkm));
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic load_mode(input logic [1:0] ch, input logic [4:0] w);
		ml = ch;
		mw = w;
		step(1);
		ml = 2'h0;
	endtask
	task tally_and_finish;
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// A hang costs about 1700 cycles over the planned run of about 280
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		step(4);
		rst_b = 1'b1;
		step(1);
		chk("leak", 2'h3, lkm);
		chk("level", 4'hF, lvs);
		chk("ground", 2'h3, lgd);
		for (int i = 0; i < 64; i++) begin
			v = i[5:0];
			dl = {1'b1, v[1]};
			rs = {1'b0, v[2]};
			lo = {1'b1, v[0]};
			load_mode(2'h1, {v[5], v[4], 2'h0, v[3]});
			step(3);
			elv = v[5] ? PCM_LVL_NONE : !v[2] ? (v[1] ? PCM_LVL_HIGH : PCM_LVL_LOW)
				: (v[4] ? PCM_LVL_TERM : PCM_LVL_NONE);
			ecl = !v[5] && v[2] && !v[4];
			eld = !v[5] && (v[3] || v[0]);
			chk("level", {PCM_LVL_NONE, elv}, lvs);
			chk("clamp", {1'b0, ecl}, cen);
			chk("load", {1'b0, eld}, len);
			chk("bridge", {1'b0, eld}, lbr);
			chk("drive", {1'b0, !v[5] && !(v[2] && !v[4])}, den);
			chk("leak", {1'b1, v[5]}, lkm);
			chk("ground", {1'b1, !eld}, lgd);
		end
		for (int c = 0; c < 4; c++) begin
			load_mode(2'h3, {3'h0, c[1:0]} << 1);
			es = PCM_RATE_100 - PCM_RATE_25 * c[6:0];
			chk("slew", {es, es}, slw);
			step(1);
		end
		// Both channels out of leakage: channel 1 drives high, channel 0 listens
		chk("level", {PCM_LVL_HIGH, PCM_LVL_NONE}, lvs);
		chk("clamp", 2'h1, cen);
		chk("drive", 2'h2, den);
		chk("load", 2'h3, len);
		// Mid-run reset must force both channels back into leakage
		rst_b = 1'b0;
		step(1);
		chk("leak", 2'h3, lkm);
		chk("level", 4'hF, lvs);
		chk("slew", {PCM_RATE_100, PCM_RATE_100}, slw);
		rst_b = 1'b1;
		load_mode(2'h1, 5'h10);
		hr = 2'h1;
		lr = 2'h2;
		step(4);
		chk("cmp", 4'h6, {hco, lco});
		hr = 2'h2;
		lr = 2'h1;
		step(4);
		chk("cmp", 4'h9, {hco, lco});
		tally_and_finish();
	end
endmodule
bind pcm_top pcm_props #(.NUM_CH(NUM_CH)) props_u (.ref_clk(ref_clk), .rst_b(rst_b),
	.mode_load(mode_load), .mode_word(mode_word), .high_cmp_raw(high_cmp_raw),
	.low_cmp_raw(low_cmp_raw), .high_compare_out(high_compare_out),
	.low_compare_out(low_compare_out), .level_sel(level_sel), .drive_en(drive_en),
	.slew_pct(slew_pct), .clamp_en(clamp_en), .load_en(load_en),
	.load_to_bridge(load_to_bridge), .load_to_ground(load_to_ground), .leak_mode(leak_mode));
